// *** core/cfq_pkg.sv ***
package cfq_pkg;
  // register indices (byte address = index * 4 is not used: plain port, word index)
  localparam logic [3:0] REG_FIFO_CON     = 4'h0;
  localparam logic [3:0] REG_FIFO_STA     = 4'h1;
  localparam logic [3:0] REG_FIFO_UAH     = 4'h2;
  localparam logic [3:0] REG_FIFO_UAL     = 4'h3;
  localparam logic [3:0] REG_TEF_CONH     = 4'h4;
  localparam logic [3:0] REG_TEF_CONL     = 4'h5;
  localparam logic [3:0] REG_TEF_STA      = 4'h6;
  localparam logic [3:0] REG_TEF_UAH      = 4'h7;
  localparam logic [3:0] REG_TEF_UAL      = 4'h8;
  localparam logic [3:0] REG_MODE         = 4'h9;
  // message fifo control fields
  localparam int FC_RESET   = 10;
  localparam int FC_SEND    = 9;
  localparam int FC_ADV     = 8;
  localparam int FC_DIR     = 7;
  localparam int FC_SIZE_LO = 0;
  // message fifo status fields
  localparam int FS_IDX_LO  = 8;
  localparam int FS_ABT     = 7;
  localparam int FS_LARB    = 6;
  localparam int FS_ERR     = 5;
  localparam int FS_EF      = 2;
  localparam int FS_HALF    = 1;
  localparam int FS_SC      = 0;
  // event fifo fields
  localparam int TH_SIZE_LO = 8;
  localparam int TL_RESET   = 10;
  localparam int TL_ADV     = 8;
  localparam int TL_TS      = 5;
  localparam int TL_OVIE    = 3;
  localparam int TL_FIE     = 2;
  localparam int TL_HIE     = 1;
  localparam int TL_NEIE    = 0;
  localparam int TS_OV      = 3;
  localparam int TS_FULL    = 2;
  localparam int TS_HALF    = 1;
  localparam int TS_NE      = 0;
  // reset values, configuration mode code and element sizes
  localparam logic [2:0]  MODE_CONFIG   = 3'h4;
  localparam logic [2:0]  MODE_RST      = 3'h4;
  localparam logic [4:0]  SIZE_RST      = 5'h00;
  localparam logic [31:0] TEF_BASE_RST  = 32'h0000_0000;
  localparam logic [31:0] FIFO_BASE_RST = 32'h0000_0400;
  localparam logic [7:0]  ELEM_BYTES    = 8'h0c;
  localparam logic [7:0]  ELEM_TS_BYTES = 8'h10;
  localparam logic [7:0]  MSG_BYTES     = 8'h48;

  typedef struct packed {
    logic ov;
    logic full;
    logic half;
    logic ne;
  } cfq_tef_flags_s;

  typedef struct packed {
    logic done;
    logic abort;
    logic arb_lost;
    logic bus_err;
  } cfq_tx_result_s;
endpackage : cfq_pkg

// *** core/cfq_queue_status.sv ***
// The address map and strobed register access were chosen for this implementation.
`timescale 1ns/1ps
// How it works
// R1: transmit fifo: empty/full flag set when nothing queued, clear while messages wait.
// R2: receive fifo: same flag shows full, clear when space exists.
// R3: transmit fifo: half flag set while occupancy at or below half depth.
// R4: receive fifo: half flag set while occupancy at or above half depth.
// R5: transmit fifo: lowest flag set while at least one slot is free.
// R6: receive fifo: lowest flag set while at least one message is stored.
// R7: message index is zero based, zero up to the depth code.
// R8: arbitration-lost and bus-error bits change only on completion, abort or reset.
// R9: aborted bit clears on status read, queue reset, send request or write.
// R10: event fifo depth is five-bit code plus one, 1 to 32 entries.
// R11: event depth and timestamp enable change only in configuration mode.
// R12: event reset bit resets the fifo, then hardware clears the bit.
// R13: event advance bit moves tail by exactly one element; zero does nothing.
// R14: with timestamp enable each event element also stores a timestamp.
// R15: four event interrupt enables: overflow, full, half, not empty.
// R16: event overflow flag set on overflow, held until cleared.
// R17: event full, half and not-empty flags follow occupancy, read only.
// R18: transmit fifo user address returns the head address.
// R19: receive fifo user address returns the tail address.
// R20: software reads user address only outside configuration mode.
// R21: direction bit one means transmit, zero means receive.
// R22: send request clears when all sent; software clear requests abort.
// R23: each fifo raises one request from any enabled set flag.
// R24: event reset returns head and tail to the first element, empty.
module cfq_queue_status #(
  parameter int DEPTH_BITS = 5
) (
  // clock and reset
  input  wire logic                    mclk_in,
  input  wire logic                    rst_n_in,
  // register port
  input  wire logic [3:0]              reg_addr_in,
  input  wire logic [15:0]             reg_wdata_in,
  input  wire logic                    reg_wr_in,
  input  wire logic                    reg_rd_in,
  output logic      [15:0]             reg_rdata_out,
  // protocol engine events, message fifo
  input  wire logic                    msg_put_in,
  input  wire logic                    msg_take_in,
  input  wire cfq_pkg::cfq_tx_result_s tx_result_in,
  // protocol engine events, event fifo
  input  wire logic                    tef_put_in,
  output logic                         tef_store_ts_out,
  // interrupt requests
  output logic                         fifo_irq_out,
  output logic                         tef_irq_out,
  // control seen by the engine
  output logic                         send_request_out,
  output logic                         abort_request_out
);

  // pointers and depth codes are five bits wide throughout
  if (DEPTH_BITS != 5) begin : g_bad_depth
    $error("cfq_queue_status: DEPTH_BITS must be 5");
  end

  localparam int CW = DEPTH_BITS + 1;

  // message fifo state
  logic [15:0]           fcon_ff;
  logic [DEPTH_BITS-1:0] f_head_ff;
  logic [DEPTH_BITS-1:0] f_tail_ff;
  logic [CW-1:0]         f_cnt_ff;
  logic                  abt_ff;
  logic                  larb_ff;
  logic                  berr_ff;
  // event fifo state
  logic [4:0]            tef_size_ff;
  logic [5:0]            tef_ctl_ff;
  logic                  tef_rst_ff;
  logic [DEPTH_BITS-1:0] t_head_ff;
  logic [DEPTH_BITS-1:0] t_tail_ff;
  logic [CW-1:0]         t_cnt_ff;
  logic                  tef_ov_ff;
  logic [2:0]            mode_ff;
  logic [15:0]           nxt_rdata;

  function automatic logic [CW-1:0] depth_of(input logic [4:0] code);
    depth_of = CW'(code) + CW'(1); // [R10]
  endfunction : depth_of

  function automatic logic [DEPTH_BITS-1:0] wrap_inc(input logic [DEPTH_BITS-1:0] p, input logic [4:0] code);
    wrap_inc = (p == code) ? '0 : p + 1'b1;
  endfunction : wrap_inc

  // one register strobe decoded against one word index
  function automatic logic hit(input logic strobe, input logic [3:0] addr, input logic [3:0] idx);
    hit = strobe && (addr == idx);
  endfunction : hit

  logic          cfg_mode;
  logic          is_tx;
  logic [4:0]    f_size;
  logic [CW-1:0] f_depth;
  logic [CW-1:0] t_depth;
  logic          f_full;
  logic          f_empty;
  logic          wr_fcon;
  logic          f_reset;
  logic          f_adv;
  logic          t_adv;
  logic          t_overflow;
  logic          wr_mode;
  logic          wr_tconh;
  logic          wr_tconl;
  logic          wr_tsta;
  logic          rd_fsta;
  logic          f_inc;
  logic          f_dec;
  logic          t_inc;
  logic          t_full;
  logic          t_empty;
  cfq_pkg::cfq_tef_flags_s tflags;

  assign cfg_mode = (mode_ff == cfq_pkg::MODE_CONFIG);
  assign is_tx    = fcon_ff[cfq_pkg::FC_DIR]; // [R21]
  assign f_size   = fcon_ff[cfq_pkg::FC_SIZE_LO +: 5];
  assign f_depth  = depth_of(f_size);
  assign t_depth  = depth_of(tef_size_ff);
  assign f_full   = (f_cnt_ff == f_depth);
  assign f_empty  = (f_cnt_ff == '0);
  assign wr_fcon  = hit(reg_wr_in, reg_addr_in, cfq_pkg::REG_FIFO_CON);
  assign wr_mode  = hit(reg_wr_in, reg_addr_in, cfq_pkg::REG_MODE);
  assign wr_tconh = hit(reg_wr_in, reg_addr_in, cfq_pkg::REG_TEF_CONH);
  assign wr_tconl = hit(reg_wr_in, reg_addr_in, cfq_pkg::REG_TEF_CONL);
  assign wr_tsta  = hit(reg_wr_in, reg_addr_in, cfq_pkg::REG_TEF_STA);
  assign rd_fsta  = hit(reg_rd_in, reg_addr_in, cfq_pkg::REG_FIFO_STA);
  assign f_reset  = wr_fcon && reg_wdata_in[cfq_pkg::FC_RESET];
  assign f_adv    = wr_fcon && reg_wdata_in[cfq_pkg::FC_ADV];
  // transmit: software fills the head, the engine drains the tail; receive the other way round
  assign f_inc    = is_tx ? (f_adv && !f_full) : (msg_put_in && !f_full);
  assign f_dec    = is_tx ? (msg_take_in && !f_empty) : (f_adv && !f_empty);
  assign t_full   = (t_cnt_ff == t_depth);
  assign t_empty  = (t_cnt_ff == '0);
  assign t_inc    = tef_put_in && !t_full;
  assign t_adv    = wr_tconl && reg_wdata_in[cfq_pkg::TL_ADV] && !t_empty; // [R13]
  assign t_overflow = tef_put_in && t_full;

  // operating mode
  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      mode_ff <= cfq_pkg::MODE_RST;
    end else if (wr_mode) begin
      mode_ff <= reg_wdata_in[2:0];
    end
  end

  // message fifo control; send request auto-clears when drained
  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      fcon_ff <= '0;
    end else if (wr_fcon) begin
      fcon_ff <= {6'h00, reg_wdata_in[cfq_pkg::FC_SEND] & reg_wdata_in[cfq_pkg::FC_DIR], 1'b0, reg_wdata_in[7:0]};
    end else if (is_tx && fcon_ff[cfq_pkg::FC_SEND] && tx_result_in.done
                 && f_cnt_ff == CW'(1) && msg_take_in) begin
      fcon_ff[cfq_pkg::FC_SEND] <= 1'b0; // [R22]
    end
  end

  assign send_request_out  = fcon_ff[cfq_pkg::FC_SEND];
  assign abort_request_out = wr_fcon && is_tx && fcon_ff[cfq_pkg::FC_SEND]
                             && !reg_wdata_in[cfq_pkg::FC_SEND]; // [R22]

  // message fifo pointers and occupancy; a reset clears everything
  always_ff @(posedge mclk_in) begin
    if (!rst_n_in || f_reset) begin
      f_head_ff <= '0;
      f_tail_ff <= '0;
      f_cnt_ff  <= '0;
    end else begin
      if (f_inc) f_head_ff <= wrap_inc(f_head_ff, f_size);
      if (f_dec) f_tail_ff <= wrap_inc(f_tail_ff, f_size);
      if (f_inc && !f_dec) f_cnt_ff <= f_cnt_ff + 1'b1;
      else if (f_dec && !f_inc) f_cnt_ff <= f_cnt_ff - 1'b1;
    end
  end

  // transmit outcome bits
  always_ff @(posedge mclk_in) begin
    if (!rst_n_in || f_reset) begin
      larb_ff <= 1'b0; // [R8]
      berr_ff <= 1'b0;
    end else if (tx_result_in.done || tx_result_in.abort) begin
      larb_ff <= tx_result_in.arb_lost; // [R8]
      berr_ff <= tx_result_in.bus_err;
    end
  end

  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      abt_ff <= 1'b0;
    end else if (tx_result_in.abort) begin
      abt_ff <= 1'b1;
    end else if (f_reset || wr_fcon || rd_fsta) begin
      abt_ff <= 1'b0; // [R9]
    end
  end

  // event fifo configuration; depth and timestamp enable only in configuration mode, interrupt enables in any mode
  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      tef_size_ff <= cfq_pkg::SIZE_RST;
    end else if (wr_tconh && cfg_mode) begin
      tef_size_ff <= reg_wdata_in[cfq_pkg::TH_SIZE_LO +: 5]; // [R11]
    end
  end

  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      tef_ctl_ff <= '0;
    end else if (wr_tconl) begin
      tef_ctl_ff[3:0] <= reg_wdata_in[3:0]; // [R15]
      if (cfg_mode) tef_ctl_ff[cfq_pkg::TL_TS] <= reg_wdata_in[cfq_pkg::TL_TS]; // [R11]
    end
  end

  // reset bit: set by write, cleared by hardware one cycle later, on the same edge that resets the fifo
  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      tef_rst_ff <= 1'b0;
    end else if (tef_rst_ff) begin
      tef_rst_ff <= 1'b0; // [R12]
    end else if (wr_tconl && reg_wdata_in[cfq_pkg::TL_RESET]) begin
      tef_rst_ff <= 1'b1; // [R12]
    end
  end

  // event fifo pointers; an overflowing put is dropped
  always_ff @(posedge mclk_in) begin
    if (!rst_n_in || tef_rst_ff) begin
      t_head_ff <= '0; // [R24]
      t_tail_ff <= '0;
      t_cnt_ff  <= '0;
    end else begin
      if (t_inc) t_head_ff <= wrap_inc(t_head_ff, tef_size_ff);
      if (t_adv) t_tail_ff <= wrap_inc(t_tail_ff, tef_size_ff); // [R13]
      if (t_inc && !t_adv) t_cnt_ff <= t_cnt_ff + 1'b1;
      else if (t_adv && !t_inc) t_cnt_ff <= t_cnt_ff - 1'b1;
    end
  end

  // overflow flag: set wins over software clear
  always_ff @(posedge mclk_in) begin
    if (!rst_n_in || tef_rst_ff) begin
      tef_ov_ff <= 1'b0;
    end else if (t_overflow) begin
      tef_ov_ff <= 1'b1; // [R16]
    end else if (wr_tsta && !reg_wdata_in[cfq_pkg::TS_OV]) begin
      tef_ov_ff <= 1'b0; // [R16]
    end
  end

  assign tef_store_ts_out = tef_put_in && tef_ctl_ff[cfq_pkg::TL_TS]; // [R14]

  always_comb begin
    tflags.ov   = tef_ov_ff;
    tflags.full = t_full; // [R17]
    tflags.half = ({t_cnt_ff, 1'b0} >= {1'b0, t_depth}); // [R17]
    tflags.ne   = !t_empty; // [R17]
  end

  // message fifo level flags, meaning set by direction
  logic [2:0] fflags;
  always_comb begin
    if (is_tx) begin
      fflags[2] = f_empty; // [R1]
      fflags[1] = ({f_cnt_ff, 1'b0} <= {1'b0, f_depth}); // [R3]
      fflags[0] = !f_full; // [R5]
    end else begin
      fflags[2] = f_full; // [R2]
      fflags[1] = ({f_cnt_ff, 1'b0} >= {1'b0, f_depth}); // [R4]
      fflags[0] = !f_empty; // [R6]
    end
  end

  assign fifo_irq_out = |(fflags & fcon_ff[2:0]); // [R23]
  assign tef_irq_out  = |(tflags & tef_ctl_ff[3:0]); // [R15] [R23]

  // user addresses: head for transmit, tail for receive
  logic [31:0] f_ua;
  logic [31:0] t_ua;
  logic [7:0]  t_elem;
  assign f_ua   = cfq_pkg::FIFO_BASE_RST
                  + 32'(is_tx ? f_head_ff : f_tail_ff) * 32'(cfq_pkg::MSG_BYTES); // [R18] [R19]
  assign t_elem = tef_ctl_ff[cfq_pkg::TL_TS] ? cfq_pkg::ELEM_TS_BYTES : cfq_pkg::ELEM_BYTES;
  assign t_ua   = cfq_pkg::TEF_BASE_RST + 32'(t_tail_ff) * 32'(t_elem);

  // read mux
  always_comb begin
    nxt_rdata = '0;
    unique case (reg_addr_in)
      cfq_pkg::REG_FIFO_CON: nxt_rdata = fcon_ff;
      cfq_pkg::REG_FIFO_STA: begin
        nxt_rdata[cfq_pkg::FS_IDX_LO +: 5] = 5'(is_tx ? f_tail_ff : f_head_ff); // [R7]
        nxt_rdata[cfq_pkg::FS_ABT]  = abt_ff;
        nxt_rdata[cfq_pkg::FS_LARB] = larb_ff;
        nxt_rdata[cfq_pkg::FS_ERR]  = berr_ff;
        nxt_rdata[2:0]              = fflags;
      end
      cfq_pkg::REG_FIFO_UAH: nxt_rdata = f_ua[31:16];
      cfq_pkg::REG_FIFO_UAL: nxt_rdata = f_ua[15:0];
      cfq_pkg::REG_TEF_CONH: nxt_rdata[cfq_pkg::TH_SIZE_LO +: 5] = tef_size_ff;
      cfq_pkg::REG_TEF_CONL: begin
        nxt_rdata[5:0] = tef_ctl_ff;
        nxt_rdata[cfq_pkg::TL_RESET] = tef_rst_ff;
      end
      cfq_pkg::REG_TEF_STA:  nxt_rdata[3:0] = tflags;
      cfq_pkg::REG_TEF_UAH:  nxt_rdata = t_ua[31:16];
      cfq_pkg::REG_TEF_UAL:  nxt_rdata = t_ua[15:0];
      cfq_pkg::REG_MODE:     nxt_rdata[2:0] = mode_ff;
      default:               nxt_rdata = '0;
    endcase
  end

  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      reg_rdata_out <= '0;
    end else if (reg_rd_in) begin
      reg_rdata_out <= nxt_rdata;
    end else begin
      reg_rdata_out <= '0;
    end
  end

endmodule : cfq_queue_status

// *** bench/cfq_queue_status_props.sv ***
`timescale 1ns/1ps
module cfq_queue_status_props (
  input wire logic                    mclk_in,
  input wire logic                    rst_n_in,
  input wire logic                    reg_wr_in,
  input wire logic                    msg_put_in,
  input wire logic                    msg_take_in,
  input wire cfq_pkg::cfq_tx_result_s tx_result_in,
  input wire logic                    tef_put_in,
  input wire logic                    tef_store_ts_out,
  input wire logic                    fifo_irq_out,
  input wire logic                    tef_irq_out,
  input wire logic                    send_request_out,
  input wire logic                    abort_request_out
);
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!rst_n_in);
  logic fifo_evt;
  // anything that may move message fifo occupancy or its enables
  assign fifo_evt = msg_put_in | msg_take_in | reg_wr_in | (|tx_result_in);
  a_ts_needs_put: assert property (tef_store_ts_out |-> tef_put_in)
    else $error("timestamp store without event put");
  a_abort_on_clear: assert property (abort_request_out |-> reg_wr_in && send_request_out)
    else $error("abort request without write over a set send request");
  a_send_rise_write: assert property ($rose(send_request_out) |-> $past(reg_wr_in))
    else $error("send request rose without a write");
  a_send_fall_cause: assert property ($fell(send_request_out) |-> $past(fifo_evt) || $past(fifo_evt, 2))
    else $error("send request fell without completion or write");
  a_tef_irq_cause: assert property ($rose(tef_irq_out) |-> $past(tef_put_in || reg_wr_in))
    else $error("event irq rose without put or write");
  // a reset request empties the event fifo one cycle after its write
  a_tef_irq_quiet: assert property (!tef_put_in && !reg_wr_in && !$past(reg_wr_in) |=> $stable(tef_irq_out))
    else $error("event irq moved without put or write");
  a_fifo_irq_cause: assert property ($rose(fifo_irq_out) |-> $past(fifo_evt))
    else $error("fifo irq rose without a cause");
  a_fifo_irq_quiet: assert property (!fifo_evt |=> $stable(fifo_irq_out))
    else $error("fifo irq moved without a cause");
endmodule : cfq_queue_status_props

// *** bench/cfq_queue_status_bench.sv ***
`timescale 1ns/1ps
module cfq_queue_status_bench;
  logic                    mclk_in      = 1'b0;
  logic                    rst_n_in     = 1'b0;
  logic [3:0]              reg_addr_in  = 4'h0;
  logic [15:0]             reg_wdata_in = 16'h0000;
  logic                    reg_wr_in    = 1'b0;
  logic                    reg_rd_in    = 1'b0;
  logic                    msg_put_in   = 1'b0;
  logic                    msg_take_in  = 1'b0;
  logic                    tef_put_in   = 1'b0;
  cfq_pkg::cfq_tx_result_s tx_result_in = '0;
  logic [15:0]             reg_rdata_out;
  logic                    tef_store_ts_out, fifo_irq_out, tef_irq_out, send_request_out, abort_request_out;
  logic                    wr_abort, ts_seen;
  logic [15:0]             rd_val;
  int                      n_mismatch = 0;
  int                      checks = 0;

  always #12.5 mclk_in = ~mclk_in;

  cfq_queue_status cfq_queue_status_i (.mclk_in(mclk_in), .rst_n_in(rst_n_in), .reg_addr_in(reg_addr_in),
    .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out),
    .msg_put_in(msg_put_in), .msg_take_in(msg_take_in), .tx_result_in(tx_result_in), .tef_put_in(tef_put_in),
    .tef_store_ts_out(tef_store_ts_out), .fifo_irq_out(fifo_irq_out), .tef_irq_out(tef_irq_out),
    .send_request_out(send_request_out), .abort_request_out(abort_request_out));

  task automatic cmp(input string what, input logic [15:0] exp, input logic [15:0] got);
    checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask : cmp

  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge mclk_in);
    reg_wr_in    <= 1'b1;
    reg_addr_in  <= a;
    reg_wdata_in <= d;
    #1 wr_abort = abort_request_out;
    @(posedge mclk_in);
    reg_wr_in <= 1'b0;
    // callers look at outputs only after this edge's updates have settled
    #1;
  endtask : wr

  // read data stand only in the cycle after the strobe
  task automatic chk(input string what, input logic [3:0] a, input logic [15:0] mask, input logic [15:0] exp);
    @(posedge mclk_in);
    reg_rd_in   <= 1'b1;
    reg_addr_in <= a;
    @(posedge mclk_in);
    reg_rd_in <= 1'b0;
    #1 rd_val = reg_rdata_out;
    cmp(what, exp, rd_val & mask);
  endtask : chk

  task automatic chk_ua(input logic [3:0] hi, input logic [3:0] lo, input logic [31:0] exp);
    chk("address high", hi, 16'hffff, exp[31:16]);
    chk("address low", lo, 16'hffff, exp[15:0]);
  endtask : chk_ua

  // kind 0 stores a received message, 1 sends one, 2 writes an event, 3 reports a result only
  task automatic pulse(input int kind, input logic [3:0] res);
    @(posedge mclk_in);
    msg_put_in   <= (kind == 0);
    msg_take_in  <= (kind == 1);
    tef_put_in   <= (kind == 2);
    tx_result_in <= cfq_pkg::cfq_tx_result_s'(res);
    #1 ts_seen = tef_store_ts_out;
    @(posedge mclk_in);
    {msg_put_in, msg_take_in, tef_put_in} <= 3'b000;
    tx_result_in <= '0;
    #1;
  endtask : pulse

  task automatic test_reset();
    chk("event status", cfq_pkg::REG_TEF_STA, 16'hffff, 16'h0000);
    chk("fifo status", cfq_pkg::REG_FIFO_STA, 16'h1fe7, 16'h0000);
    chk("unmapped", 4'hf, 16'hffff, 16'h0000);
    chk("mode", cfq_pkg::REG_MODE, 16'h0007, {13'h0000, cfq_pkg::MODE_RST});
    $display("test reset done");
  endtask : test_reset

  task automatic test_rx();
    int m;
    wr(cfq_pkg::REG_FIFO_CON, 16'h0003);
    wr(cfq_pkg::REG_MODE, 16'h0000);
    for (int n = 1; n <= 5; n++) begin
      pulse(0, 4'h0);
      m = (n > 4) ? 4 : n;
      chk("rx status", cfq_pkg::REG_FIFO_STA, 16'h1f07, {3'b000, 5'(m % 4), 5'b00000, m == 4, m >= 2, m >= 1});
      cmp("rx irq", 16'(m >= 1), 16'(fifo_irq_out));
    end
    wr(cfq_pkg::REG_FIFO_CON, 16'h0103);
    chk("rx after advance", cfq_pkg::REG_FIFO_STA, 16'h1f07, 16'h0003);
    chk_ua(cfq_pkg::REG_FIFO_UAH, cfq_pkg::REG_FIFO_UAL, cfq_pkg::FIFO_BASE_RST + 32'(cfq_pkg::MSG_BYTES));
    $display("test rx done");
  endtask : test_rx

  task automatic test_tx();
    wr(cfq_pkg::REG_FIFO_CON, 16'h0483);
    chk("tx empty", cfq_pkg::REG_FIFO_STA, 16'h1f07, 16'h0007);
    cmp("tx irq", 16'h0001, 16'(fifo_irq_out));
    for (int k = 0; k < 3; k++) wr(cfq_pkg::REG_FIFO_CON, 16'h0183);
    chk("tx three", cfq_pkg::REG_FIFO_STA, 16'h1f07, 16'h0001);
    chk_ua(cfq_pkg::REG_FIFO_UAH, cfq_pkg::REG_FIFO_UAL, cfq_pkg::FIFO_BASE_RST + 32'h0000_00d8);
    wr(cfq_pkg::REG_FIFO_CON, 16'h0283);
    cmp("send set", 16'h0001, 16'(send_request_out));
    pulse(1, 4'b1010);
    chk("tx lost", cfq_pkg::REG_FIFO_STA, 16'h1f67, 16'h0143);
    pulse(1, 4'b1000);
    pulse(1, 4'b1000);
    cmp("send auto clear", 16'h0000, 16'(send_request_out));
    chk("tx drained", cfq_pkg::REG_FIFO_STA, 16'h1f67, 16'h0307);
    wr(cfq_pkg::REG_FIFO_CON, 16'h0183);
    wr(cfq_pkg::REG_FIFO_CON, 16'h0283);
    wr(cfq_pkg::REG_FIFO_CON, 16'h0083);
    cmp("abort pulse", 16'h0001, 16'(wr_abort));
    pulse(3, 4'b0110);
    chk("tx aborted", cfq_pkg::REG_FIFO_STA, 16'h1fe7, 16'h03c3);
    chk("abort read clear", cfq_pkg::REG_FIFO_STA, 16'h1fe7, 16'h0343);
    $display("test tx done");
  endtask : test_tx

  task automatic test_tef();
    int m;
    wr(cfq_pkg::REG_MODE, 16'h0004);
    wr(cfq_pkg::REG_TEF_CONH, 16'h0300);
    wr(cfq_pkg::REG_TEF_CONL, 16'h002f);
    wr(cfq_pkg::REG_MODE, 16'h0000);
    for (int n = 1; n <= 5; n++) begin
      pulse(2, 4'h0);
      cmp("timestamp", 16'h0001, 16'(ts_seen));
      m = (n > 4) ? 4 : n;
      chk("event status", cfq_pkg::REG_TEF_STA, 16'hffff, {12'h000, n == 5, m == 4, m >= 2, m >= 1});
      cmp("event irq", 16'h0001, 16'(tef_irq_out));
    end
    wr(cfq_pkg::REG_TEF_CONH, 16'h1f00);
    chk("depth held", cfq_pkg::REG_TEF_CONH, 16'hffff, 16'h0300);
    wr(cfq_pkg::REG_TEF_CONL, 16'h012f);
    chk("event advance", cfq_pkg::REG_TEF_STA, 16'hffff, 16'h000b);
    chk_ua(cfq_pkg::REG_TEF_UAH, cfq_pkg::REG_TEF_UAL, cfq_pkg::TEF_BASE_RST + 32'(cfq_pkg::ELEM_TS_BYTES));
    wr(cfq_pkg::REG_TEF_STA, 16'h0000);
    chk("overflow clear", cfq_pkg::REG_TEF_STA, 16'hffff, 16'h0003);
    wr(cfq_pkg::REG_TEF_CONL, 16'h042f);
    chk("reset bit", cfq_pkg::REG_TEF_CONL, 16'h0400, 16'h0000);
    chk("event reset", cfq_pkg::REG_TEF_STA, 16'hffff, 16'h0000);
    cmp("event irq off", 16'h0000, 16'(tef_irq_out));
    chk_ua(cfq_pkg::REG_TEF_UAH, cfq_pkg::REG_TEF_UAL, cfq_pkg::TEF_BASE_RST);
    wr(cfq_pkg::REG_MODE, 16'h0004);
    wr(cfq_pkg::REG_TEF_CONL, 16'h000f);
    pulse(2, 4'h0);
    cmp("no timestamp", 16'h0000, 16'(ts_seen));
    $display("test event done");
  endtask : test_tef

  task automatic conclude();
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : conclude

  initial begin
    repeat (20) @(posedge mclk_in);
    rst_n_in <= 1'b1;
    test_reset();
    test_rx();
    test_tx();
    test_tef();
    conclude();
  end

  initial begin
    repeat (4000) @(posedge mclk_in);
    n_mismatch++;
    conclude();
  end
endmodule : cfq_queue_status_bench

bind cfq_queue_status cfq_queue_status_props cfq_queue_status_props_i (.mclk_in(mclk_in), .rst_n_in(rst_n_in),
  .reg_wr_in(reg_wr_in), .msg_put_in(msg_put_in), .msg_take_in(msg_take_in), .tx_result_in(tx_result_in),
  .tef_put_in(tef_put_in), .tef_store_ts_out(tef_store_ts_out), .fifo_irq_out(fifo_irq_out),
  .tef_irq_out(tef_irq_out), .send_request_out(send_request_out), .abort_request_out(abort_request_out));
